// file: htsc_defines.svh
// Constants for the hub sideband control block.
// Assumes inclusion by its bare name from the package and modules.
`ifndef HTSC_DEFINES_SVH
`define HTSC_DEFINES_SVH
// Input synchroniser depth
`define HTSC_SYNC_STAGES 2
// Reset value of the control mode select bit (pull-down default)
`define HTSC_MODE_RST 1'b0
// Speed indicator levels
`define HTSC_SPEED_GEN1 1'b0
`define HTSC_SPEED_USB2 1'b1
// Input vector field positions
`define HTSC_IN_MODE 0
`define HTSC_IN_POL 1
`define HTSC_IN_ATT 2
`define HTSC_IN_ORI 3
`define HTSC_IN_ATA 4
`define HTSC_IN_ATB 5
`define HTSC_IN_W 6
`endif

// file: htsc_pkg.sv
// Types for the hub sideband control block.
// Assumes htsc_defines.svh is on the include path.
`include "htsc_defines.svh"
package htsc_pkg;
    // Host connection speed as seen by the hub core
    typedef enum logic [1:0] {
        HTSC_SPD_NONE = 2'b00,
        HTSC_SPD_GEN1 = 2'b01,
        HTSC_SPD_USB2 = 2'b10
    } htsc_speed_t;
    // Two-wire interface role
    typedef enum logic {
        HTSC_ROLE_TARGET = 1'b0,
        HTSC_ROLE_BRIDGE = 1'b1
    } htsc_role_t;
    // PHY enable pair
    typedef struct packed {
        logic phy_b;
        logic phy_a;
    } htsc_phy_en_t;
endpackage : htsc_pkg

// file: htsc_sync.sv
// Multi-bit two-flop synchroniser for static sideband levels.
// Assumes each bit is an independent slow level.
`include "htsc_defines.svh"
module htsc_sync #(
    parameter int WIDTH = `HTSC_IN_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Raw and synchronised levels
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta; // First stage, read only by second stage

    ////////////////////////////////////////////////////////////////////////
    // Two stages per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    meta[i] <= 1'b0;
                    q[i] <= 1'b0;
                end else begin
                    meta[i] <= d[i];
                    q[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule : htsc_sync

// file: htsc_ctrl.sv
// Sideband control: connector mode/orientation, two-wire role, indicators.
// Assumes a 40 MHz clk; pins are plain synchronous-style ports.
`include "htsc_defines.svh"
module htsc_ctrl (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Connector control inputs
    input wire logic control_mode_select,
    input wire logic attach_polarity_in,
    input wire logic attach_detect_in,
    input wire logic orientation_select_in,
    input wire logic orient_a_attach_in,
    input wire logic orient_b_attach_in,
    // Hub core status
    input wire htsc_pkg::htsc_speed_t host_speed,
    input wire logic usb2_suspended,
    input wire logic role_config,
    // PHY enables
    output htsc_pkg::htsc_phy_en_t phy_en,
    // Two-wire role
    output htsc_pkg::htsc_role_t twi_role,
    // Indicators (three-signal pins)
    output logic [1:0] speed_ind_out,
    output logic [1:0] speed_ind_oe,
    output logic suspend_indicator,
    output logic mode2_active
);
    import htsc_pkg::*;

    logic [`HTSC_IN_W-1:0] raw_in; // Raw sideband bundle
    logic [`HTSC_IN_W-1:0] syn_in; // Synchronised bundle
    logic mode2; // Control mode two selected
    logic inv; // Active-low interpretation
    logic att; // Attach, true polarity
    logic ori; // Orientation, true polarity
    logic ata; // Orientation A attach, true polarity
    logic atb; // Orientation B attach, true polarity
    htsc_phy_en_t next_phy_en; // Next PHY enables

    ////////////////////////////////////////////////////////////////////////
    // Bundle and synchronise; unconnected mode pin is pulled low outside
    assign raw_in = {orient_b_attach_in, orient_a_attach_in, orientation_select_in,
                     attach_detect_in, attach_polarity_in, control_mode_select};
    htsc_sync #(.WIDTH(`HTSC_IN_W)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d(raw_in),
        .q(syn_in)
    );

    ////////////////////////////////////////////////////////////////////////
    // Polarity interpretation
    assign mode2 = syn_in[`HTSC_IN_MODE];
    assign inv = syn_in[`HTSC_IN_POL];
    assign att = syn_in[`HTSC_IN_ATT] ^ inv;
    assign ori = syn_in[`HTSC_IN_ORI] ^ inv;
    assign ata = syn_in[`HTSC_IN_ATA] ^ inv;
    assign atb = syn_in[`HTSC_IN_ATB] ^ inv;

    ////////////////////////////////////////////////////////////////////////
    // PHY selection per mode
    always_comb begin
        next_phy_en = '0;
        if (mode2) begin
            // Each orientation PHY on only while its attach is present
            next_phy_en.phy_a = ata;
            next_phy_en.phy_b = atb;
        end else begin
            // Orientation picks the PHY, gated by attach
            next_phy_en.phy_b = att & ori;
            next_phy_en.phy_a = att & ~ori;
        end
    end

    // PHY enable register; reset holds all off
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phy_en <= '0;
            mode2_active <= `HTSC_MODE_RST;
        end else begin
            phy_en <= next_phy_en;
            mode2_active <= mode2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-wire role from configuration
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            twi_role <= HTSC_ROLE_TARGET;
        end else begin
            twi_role <= role_config ? HTSC_ROLE_BRIDGE : HTSC_ROLE_TARGET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Speed indicators: released when no host is connected
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            speed_ind_out <= '0;
            speed_ind_oe <= '0;
        end else begin
            unique case (host_speed)
                HTSC_SPD_GEN1: begin
                    speed_ind_out <= {2{`HTSC_SPEED_GEN1}};
                    speed_ind_oe <= 2'h3;
                end
                HTSC_SPD_USB2: begin
                    speed_ind_out <= {2{`HTSC_SPEED_USB2}};
                    speed_ind_oe <= 2'h3;
                end
                default: begin
                    // Not connected or illegal code: float
                    speed_ind_out <= '0;
                    speed_ind_oe <= '0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Suspend indicator
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            suspend_indicator <= 1'b0;
        end else begin
            suspend_indicator <= usb2_suspended;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_mode1_b;
        @(posedge clk) disable iff (!arst_n)
        (arst_n && !control_mode_select && !attach_polarity_in && attach_detect_in
         && orientation_select_in)[*4] |-> phy_en == 2'b10;
    endproperty
    a_mode1_b: assert property (p_mode1_b) else $error("mode1 PHY B not chosen");
    property p_mode1_a;
        @(posedge clk) disable iff (!arst_n)
        (arst_n && !control_mode_select && !attach_polarity_in && attach_detect_in
         && !orientation_select_in)[*4] |-> phy_en == 2'b01;
    endproperty
    a_mode1_a: assert property (p_mode1_a) else $error("mode1 PHY A not chosen");
    property p_mode2;
        @(posedge clk) disable iff (!arst_n)
        (arst_n && control_mode_select && !attach_polarity_in)[*4] |->
        phy_en == {$past(orient_b_attach_in, 3), $past(orient_a_attach_in, 3)};
    endproperty
    a_mode2: assert property (p_mode2) else $error("mode2 PHY enables wrong");
    property p_inv;
        @(posedge clk) disable iff (!arst_n)
        (arst_n && control_mode_select && attach_polarity_in)[*4] |->
        phy_en == ~{$past(orient_b_attach_in, 3), $past(orient_a_attach_in, 3)};
    endproperty
    a_inv: assert property (p_inv) else $error("inverted polarity wrong");
    property p_onehot1;
        @(posedge clk) disable iff (!arst_n)
        (arst_n && !control_mode_select)[*4] |-> phy_en != 2'b11;
    endproperty
    a_onehot1: assert property (p_onehot1) else $error("mode1 both PHYs on");
    property p_mode_flag;
        @(posedge clk) disable iff (!arst_n)
        (arst_n && control_mode_select)[*4] |-> mode2_active;
    endproperty
    a_mode_flag: assert property (p_mode_flag) else $error("mode2 flag not set");
    property p_speed;
        @(posedge clk) disable iff (!arst_n)
        arst_n && host_speed == HTSC_SPD_GEN1 |=>
        speed_ind_oe == 2'h3 && speed_ind_out == 2'h0;
    endproperty
    a_speed: assert property (p_speed) else $error("gen1 indicator wrong");
    property p_float;
        @(posedge clk) disable iff (!arst_n)
        arst_n && host_speed == HTSC_SPD_NONE |=> speed_ind_oe == 2'h0;
    endproperty
    a_float: assert property (p_float) else $error("indicator not floated");
    property p_susp;
        @(posedge clk) disable iff (!arst_n)
        arst_n |=> suspend_indicator == $past(usb2_suspended);
    endproperty
    a_susp: assert property (p_susp) else $error("suspend indicator lag");
    property p_role;
        @(posedge clk) disable iff (!arst_n)
        arst_n |=> (twi_role == HTSC_ROLE_BRIDGE) == $past(role_config);
    endproperty
    a_role: assert property (p_role) else $error("role mismatch");
    // Mode one with active-low pins: both pins low means attached, PHY B
    property p_inv1;
        @(posedge clk) disable iff (!arst_n)
        (arst_n && !control_mode_select && attach_polarity_in && !attach_detect_in
         && !orientation_select_in)[*4] |-> phy_en == 2'b10;
    endproperty
    a_inv1: assert property (p_inv1) else $error("mode1 inverted PHY B not chosen");
    // Mode one without attach keeps both PHYs off
    property p_detach1;
        @(posedge clk) disable iff (!arst_n)
        (arst_n && !control_mode_select && !attach_polarity_in
         && !attach_detect_in)[*4] |-> phy_en == 2'b00;
    endproperty
    a_detach1: assert property (p_detach1) else $error("mode1 PHY on without attach");
    // Legacy-speed host drives both indicators high
    property p_usb2;
        @(posedge clk) disable iff (!arst_n)
        arst_n && host_speed == HTSC_SPD_USB2 |=>
        speed_ind_oe == 2'h3 && speed_ind_out == 2'h3;
    endproperty
    a_usb2: assert property (p_usb2) else $error("usb2 indicator wrong");
    // Unused speed code floats the indicators
    property p_bad_speed;
        @(posedge clk) disable iff (!arst_n)
        arst_n && host_speed == 2'b11 |=> speed_ind_oe == 2'h0;
    endproperty
    a_bad_speed: assert property (p_bad_speed) else $error("illegal speed not floated");
    c_m1b: cover property (@(posedge clk) disable iff (!arst_n) phy_en == 2'b10 && !mode2_active);
    c_m2a: cover property (@(posedge clk) disable iff (!arst_n) phy_en == 2'b01 && mode2_active);
    c_usb2: cover property (@(posedge clk) disable iff (!arst_n) speed_ind_out == 2'h3);
    c_susp: cover property (@(posedge clk) disable iff (!arst_n) $rose(suspend_indicator));
    c_inv1: cover property (@(posedge clk) disable iff (!arst_n) phy_en == 2'b10 && attach_polarity_in);
endmodule : htsc_ctrl

// file: htsc_conn_model.sv
// Behavioural connector controller that drives the sideband connector pins.
// Assumes the bench hands it logical attach and orientation levels on cmd.
module htsc_conn_model (
    // Clock
    input wire logic clk,
    // Logical request: mode, polarity, attach, orientation, attach A, attach B
    input wire logic [5:0] cmd,
    // Physical pin levels toward the hub
    output logic [5:0] pins = 6'h00
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////
    // Pins change just after an edge, like board logic on the same clock
    always @(posedge clk) begin
        // Mode and polarity pass straight through
        pins[5:4] <= cmd[5:4];
        // Active-low signalling when polarity is high
        pins[3:0] <= cmd[3:0] ^ {4{cmd[4]}};
    end
endmodule : htsc_conn_model

// file: htsc_ctrl_bench.sv
// Self-checking bench for the hub sideband control block.
// Assumes the connector model adds one register stage before the pins.
module htsc_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import htsc_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic clk;
    logic arst_n;
    logic [5:0] cmd; // Logical connector request
    logic [5:0] pins; // Connector pin levels
    htsc_speed_t host_speed;
    logic usb2_suspended;
    logic role_config;
    htsc_phy_en_t phy_en;
    htsc_role_t twi_role;
    logic [1:0] speed_ind_out;
    logic [1:0] speed_ind_oe;
    logic suspend_indicator;
    logic mode2_active;
    int errors = 0;
    int checks = 0;
    logic [7:0] got; // Sampled output byte
    logic [7:0] want_ind; // Expected indicator byte
    ////////////////////////////////////////////////////////////////////////
    // Design and partner
    htsc_ctrl htsc_ctrl_inst (.clk(clk), .arst_n(arst_n), .control_mode_select(pins[5]),
        .attach_polarity_in(pins[4]), .attach_detect_in(pins[3]),
        .orientation_select_in(pins[2]), .orient_a_attach_in(pins[1]),
        .orient_b_attach_in(pins[0]), .host_speed(host_speed),
        .usb2_suspended(usb2_suspended), .role_config(role_config), .phy_en(phy_en),
        .twi_role(twi_role), .speed_ind_out(speed_ind_out), .speed_ind_oe(speed_ind_oe),
        .suspend_indicator(suspend_indicator), .mode2_active(mode2_active));
    htsc_conn_model htsc_conn_model_inst (.clk(clk), .cmd(cmd), .pins(pins));
    ////////////////////////////////////////////////////////////////////////
    // Compare and report
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : complete_run
    // Expected PHY pair from a logical request
    function automatic logic [1:0] exp_phy(input logic [5:0] c);
        if (c[5]) return {c[0], c[1]};
        if (c[3]) return c[2] ? 2'b10 : 2'b01;
        return 2'b00;
    endfunction : exp_phy
    // Apply a request; old outputs hold for 3 edges, new ones after the 4th
    task automatic drive_conn(input logic [5:0] c);
        logic [2:0] old;
        logic [7:0] want;
        old = {mode2_active, phy_en};
        want = {5'h00, c[5], exp_phy(c)};
        @(posedge clk);
        cmd <= c;
        repeat (3) @(posedge clk);
        #1 check({5'h00, mode2_active, phy_en}, {5'h00, old});
        @(posedge clk);
        #1 check({5'h00, mode2_active, phy_en}, want);
    endtask : drive_conn
    ////////////////////////////////////////////////////////////////////////
    // Reference clock supplied from outside, 25 ns period
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Watchdog cuts a hang short
    initial begin
        #200us errors++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        arst_n = 1'b0;
        cmd = 6'h00;
        host_speed = HTSC_SPD_NONE;
        usb2_suspended = 1'b0;
        role_config = 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1 check({7'h00, mode2_active}, 8'h00);
        // Every mode, polarity, attach and orientation combination
        for (int i = 0; i < 64; i++) begin
            drive_conn(i[5:0]);
        end
        // Every speed code with suspend and role levels
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            host_speed <= htsc_speed_t'(i[1:0]);
            usb2_suspended <= i[2];
            role_config <= i[3];
            @(posedge clk);
            want_ind = {2'b00, {2{i[1:0] == 2'b01 || i[1:0] == 2'b10}}, {2{i[1:0] == 2'b10}},
                        i[2], i[3]};
            #1 got = {2'b00, speed_ind_oe, speed_ind_out, suspend_indicator, twi_role};
            check(got, want_ind);
        end
        // Reset in mid-run with active inputs
        drive_conn(6'h0c);
        @(posedge clk);
        host_speed <= HTSC_SPD_GEN1;
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        #1 got = {1'b0, phy_en, twi_role, speed_ind_oe, suspend_indicator, mode2_active};
        check(got, 8'h00);
        @(posedge clk);
        arst_n <= 1'b1;
        // First edge after release: indicators follow, PHYs still in the synchroniser
        @(posedge clk);
        #1 got = {1'b0, phy_en, twi_role, speed_ind_oe, suspend_indicator, mode2_active};
        check(got, 8'h1e);
        repeat (3) @(posedge clk);
        #1 check({5'h00, mode2_active, phy_en}, 8'h02);
        complete_run();
    end
endmodule : htsc_ctrl_bench
